/* File: design/psr_port.sv */
// Register bank, I2C slave and threshold interrupt of the proximity sensor.
// Assumes sample and calibration inputs come from logic on clk; pins are asynchronous.
// Operation
// - Answer as I2C slave only at the fixed 7-bit address 0x60.
// - Every access is a word transfer: command code, low byte, high byte.
// - Reading the interrupt flag register clears flags and releases the interrupt pin, except in logic mode.
// - Interrupt when result exceeds high threshold or falls below low threshold.
// - Interrupt only after the programmed count of consecutive out-of-window samples.
// - Smart persistence shortens response while still filtering false triggers.
// - Twelve-bit result is read-only, low part in low byte, high in high byte.
// - Low and high thresholds are read-write words that reset to zero.
// - Crosstalk cancellation word is read-write and is subtracted from the result.
// - Both configuration low bytes reset to 0x01, other writable bytes to 0x00.
// - Calibration result high byte also carries busy and sunlight status.
// - LED current, low power and calibration settings are read-write, resetting zero.
// - Interrupt mode field: off, logic high/low, first high, enabled.
// - Persistence field selects 1 to 4 consecutive samples.
// - Measure stop resets to 1; force mode is set before clearing stop.
`timescale 1ns/1ps
module psr_port #(
  // Identification word; the value is arbitrary.
  parameter logic [15:0] IDENT_WORD = 16'h00a5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic int_out,
  output logic int_oe,
  input wire psr_pkg::psr_sample_t sample,
  input wire psr_pkg::psr_autocal_t autocal,
  output psr_pkg::psr_cfg_t cfg,
  output logic measure_run,
  output logic force_trigger
);
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK
  } psr_state_t;

  psr_state_t state;
  logic [1:0] pins;
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] cmd;
  logic byte_hi;
  logic rd_mode;
  logic rd_more;
  logic drive_low;
  logic [15:0] low_thr;
  logic [15:0] high_thr;
  logic [15:0] cancel;
  logic [11:0] result;
  logic [1:0] flags;
  logic int_level;
  logic high_event;
  logic low_event;

  wire scl_rise = scl && !scl_d;
  wire scl_fall = !scl && scl_d;
  wire start_cond = scl && scl_d && sda_d && !sda;
  wire stop_cond = scl && scl_d && !sda_d && sda;
  wire byte_full = bit_cnt == psr_pkg::BITS_PER_BYTE;
  wire addr_hit = shreg[7:1] == psr_pkg::DEV_ADDR;
  wire wr_strobe = scl_fall && (state == S_WR) && byte_full;
  wire wr_lo = wr_strobe && !byte_hi;
  wire wr_hi = wr_strobe && byte_hi;
  wire rd_load = scl_fall && ((state == S_ADDR_ACK && rd_mode) || (state == S_RD_ACK && rd_more));
  wire rd_load_hi = (state == S_RD_ACK) ? !byte_hi : 1'b0;
  wire flag_read = rd_load && rd_load_hi && (cmd == psr_pkg::CMD_INT_FLAG);
  wire [1:0] mode = cfg.config_two_low[psr_pkg::MODE_LSB +: 2];
  wire [1:0] pers = cfg.config_two_low[psr_pkg::PERS_LSB +: 2];
  wire smart_en = cfg.config_two_low[psr_pkg::SMART_BIT];
  wire stopped = cfg.config_two_low[psr_pkg::STOP_BIT];
  wire [12:0] diff = {1'b0, sample.raw} - cancel[12:0];
  wire cancel_big = |cancel[15:12];
  // Cancellation is subtracted and the result floors at zero.
  wire [11:0] cancelled = (cancel_big || diff[12]) ? 12'h000 : diff[11:0];
  wire sample_take = sample.valid && !stopped;
  wire [7:0] ac_hi = {autocal.busy, autocal.sunlight, autocal.value[13:8]};
  wire set_high = high_event && (mode != psr_pkg::INT_OFF);
  wire set_low = low_event && (mode == psr_pkg::INT_ON || mode == psr_pkg::INT_LOGIC);
  logic [15:0] rd_word;
  wire [7:0] rd_byte = rd_load_hi ? rd_word[15:8] : rd_word[7:0];

  psr_sync #(
    .W(2),
    .RESET_VAL(2'b11)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin({scl_in, sda_in}),
    .stable(pins)
  );
  assign scl = pins[1];
  assign sda = pins[0];

  psr_persist u_persist (
    .clk(clk),
    .rst_b(rst_b),
    .sample_valid(sample_take),
    .result(cancelled),
    .low_thr(low_thr),
    .high_thr(high_thr),
    .pers_code(pers),
    .smart_en(smart_en),
    .high_event(high_event),
    .low_event(low_event)
  );

  // Read mux; the flag register sits in the high byte of its command.
  always_comb begin
    case (cmd)
      psr_pkg::CMD_CONF1: rd_word = {cfg.config_one_high, cfg.config_one_low};
      psr_pkg::CMD_CONF2: rd_word = {cfg.config_two_high, cfg.config_two_low};
      psr_pkg::CMD_CONF34: rd_word = {cfg.led_current_config, cfg.force_mode_config};
      psr_pkg::CMD_LOW_THR: rd_word = low_thr;
      psr_pkg::CMD_HIGH_THR: rd_word = high_thr;
      psr_pkg::CMD_CANCEL: rd_word = cancel;
      psr_pkg::CMD_AUTOCAL: rd_word = {cfg.low_power_config, cfg.autocal_config};
      psr_pkg::CMD_RESULT: rd_word = {4'h0, result};
      psr_pkg::CMD_INT_FLAG: rd_word = {6'h00, flags, psr_pkg::RST_ZERO};
      psr_pkg::CMD_IDENT: rd_word = IDENT_WORD;
      psr_pkg::CMD_AC_RESULT: rd_word = {ac_hi, autocal.value[7:0]};
      default: rd_word = 16'h0000;
    endcase
  end

  // Slave state machine: shift on SCL rise, drive on SCL fall.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bit_cnt <= 4'd0;
      shreg <= 8'h00;
      cmd <= 8'h00;
      byte_hi <= 1'b0;
      rd_mode <= 1'b0;
      rd_more <= 1'b0;
      drive_low <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      if (start_cond) begin
        // A repeated start keeps the command code for the read phase.
        state <= S_ADDR;
        bit_cnt <= 4'd0;
        drive_low <= 1'b0;
      end else if (stop_cond) begin
        state <= S_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            drive_low <= 1'b0;
          end
          S_ADDR, S_CMD, S_WR: begin
            if (scl_rise && !byte_full) begin
              shreg <= {shreg[6:0], sda};
              bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_fall && byte_full) begin
              bit_cnt <= 4'd0;
              drive_low <= 1'b1;
              if (state == S_ADDR) begin
                // Only the fixed address is acknowledged.
                state <= addr_hit ? S_ADDR_ACK : S_IDLE;
                drive_low <= addr_hit;
                rd_mode <= shreg[0];
              end else if (state == S_CMD) begin
                state <= S_CMD_ACK;
                cmd <= shreg;
              end else begin
                // Bytes to read-only codes are still acknowledged.
                state <= S_WR_ACK;
              end
            end
          end
          S_ADDR_ACK, S_CMD_ACK, S_WR_ACK: begin
            if (scl_fall) begin
              drive_low <= 1'b0;
              if (state == S_ADDR_ACK && rd_mode) begin
                state <= S_RD;
                shreg <= rd_byte;
                byte_hi <= 1'b0;
                drive_low <= !rd_byte[7];
              end else if (state == S_ADDR_ACK) begin
                state <= S_CMD;
              end else begin
                // Command then low byte then high byte.
                state <= S_WR;
                byte_hi <= (state == S_WR_ACK) ? !byte_hi : 1'b0;
              end
            end
          end
          S_RD: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_fall) begin
              if (byte_full) begin
                state <= S_RD_ACK;
                bit_cnt <= 4'd0;
                drive_low <= 1'b0;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                drive_low <= !shreg[6];
              end
            end
          end
          S_RD_ACK: begin
            if (scl_rise) begin
              rd_more <= !sda;
            end else if (scl_fall) begin
              if (rd_more) begin
                // Low byte was sent first; the high byte follows.
                state <= S_RD;
                shreg <= rd_byte;
                byte_hi <= !byte_hi;
                drive_low <= !rd_byte[7];
              end else begin
                state <= S_IDLE;
              end
            end
          end
          default: begin
            state <= S_IDLE;
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_low;

  // Configuration bytes with their reset values.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg.config_one_low <= psr_pkg::RST_CONF_LOW;
      cfg.config_one_high <= psr_pkg::RST_ZERO;
      cfg.config_two_low <= psr_pkg::RST_CONF_LOW;
      cfg.config_two_high <= psr_pkg::RST_ZERO;
      cfg.force_mode_config <= psr_pkg::RST_ZERO;
      cfg.led_current_config <= psr_pkg::RST_ZERO;
      cfg.autocal_config <= psr_pkg::RST_ZERO;
      cfg.low_power_config <= psr_pkg::RST_ZERO;
      low_thr <= 16'h0000;
      high_thr <= 16'h0000;
      cancel <= 16'h0000;
      force_trigger <= 1'b0;
    end else begin
      force_trigger <= 1'b0;
      if (wr_lo || wr_hi) begin
        case (cmd)
          psr_pkg::CMD_CONF1: begin
            if (wr_lo) cfg.config_one_low <= shreg;
            else cfg.config_one_high <= shreg;
          end
          psr_pkg::CMD_CONF2: begin
            if (wr_lo) cfg.config_two_low <= shreg;
            else cfg.config_two_high <= shreg;
          end
          psr_pkg::CMD_CONF34: begin
            if (wr_lo) begin
              // Trigger bit is not stored; it returns to zero by itself.
              cfg.force_mode_config <= shreg & ~(8'h01 << psr_pkg::FORCE_TRIG_BIT);
              force_trigger <= shreg[psr_pkg::FORCE_TRIG_BIT];
            end else begin
              cfg.led_current_config <= shreg;
            end
          end
          psr_pkg::CMD_LOW_THR: begin
            if (wr_lo) low_thr[7:0] <= shreg;
            else low_thr[15:8] <= shreg;
          end
          psr_pkg::CMD_HIGH_THR: begin
            if (wr_lo) high_thr[7:0] <= shreg;
            else high_thr[15:8] <= shreg;
          end
          psr_pkg::CMD_CANCEL: begin
            if (wr_lo) cancel[7:0] <= shreg;
            else cancel[15:8] <= shreg;
          end
          psr_pkg::CMD_AUTOCAL: begin
            if (wr_lo) cfg.autocal_config <= shreg;
            else cfg.low_power_config <= shreg;
          end
          default: begin
            force_trigger <= 1'b0;
          end
        endcase
      end
    end
  end

  // Result capture, sticky flags and interrupt pin.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= 12'h000;
      flags <= 2'b00;
      int_level <= 1'b0;
    end else begin
      if (sample_take) begin
        result <= cancelled;
      end
      // A new event in the read cycle survives the clear.
      flags[psr_pkg::FLAG_HIGH_BIT] <= set_high || (flags[psr_pkg::FLAG_HIGH_BIT] && !flag_read);
      flags[psr_pkg::FLAG_LOW_BIT] <= set_low || (flags[psr_pkg::FLAG_LOW_BIT] && !flag_read);
      if (mode == psr_pkg::INT_LOGIC) begin
        // Logic mode: pin goes active above high, inactive below low.
        if (high_event) int_level <= 1'b1;
        else if (low_event) int_level <= 1'b0;
      end else begin
        int_level <= 1'b0;
      end
    end
  end

  assign measure_run = !stopped;
  assign int_out = 1'b0;
  // Open-drain interrupt pulled low by the logic level in logic mode, otherwise while a flag is active and the mode is not off.
  assign int_oe = (mode == psr_pkg::INT_LOGIC) ? int_level :
    ((mode != psr_pkg::INT_OFF) && (|flags));
endmodule // psr_port

/* File: include/psr_pkg.sv */
// Constants, register map and carrier types of the proximity sensor register port.
// Assumes a single 250 MHz clock domain and the I2C pins sampled through psr_sync.
package psr_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h60;
  localparam int RESULT_W = 12;
  localparam int THR_W = 16;

  localparam logic [7:0] CMD_CONF1 = 8'h00;
  localparam logic [7:0] CMD_CONF2 = 8'h03;
  localparam logic [7:0] CMD_CONF34 = 8'h04;
  localparam logic [7:0] CMD_LOW_THR = 8'h05;
  localparam logic [7:0] CMD_HIGH_THR = 8'h06;
  localparam logic [7:0] CMD_CANCEL = 8'h07;
  localparam logic [7:0] CMD_AUTOCAL = 8'h08;
  localparam logic [7:0] CMD_RESULT = 8'hf8;
  localparam logic [7:0] CMD_INT_FLAG = 8'hf9;
  localparam logic [7:0] CMD_IDENT = 8'hfa;
  localparam logic [7:0] CMD_AC_RESULT = 8'hfb;

  localparam logic [7:0] RST_CONF_LOW = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;

  localparam int MODE_LSB = 2;
  localparam int PERS_LSB = 4;
  localparam int SMART_BIT = 1;
  localparam int STOP_BIT = 0;
  localparam int FORCE_SEL_BIT = 6;
  localparam int FORCE_TRIG_BIT = 5;
  localparam int FLAG_HIGH_BIT = 1;
  localparam int FLAG_LOW_BIT = 0;
  localparam int AC_BUSY_BIT = 7;
  localparam int AC_SUN_BIT = 6;

  localparam logic [1:0] INT_OFF = 2'b00;
  localparam logic [1:0] INT_LOGIC = 2'b01;
  localparam logic [1:0] INT_FIRST_HIGH = 2'b10;
  localparam logic [1:0] INT_ON = 2'b11;

  localparam logic [3:0] BITS_PER_BYTE = 4'd8;

  typedef struct packed {
    logic [7:0] config_one_low;
    logic [7:0] config_one_high;
    logic [7:0] config_two_low;
    logic [7:0] config_two_high;
    logic [7:0] force_mode_config;
    logic [7:0] led_current_config;
    logic [7:0] autocal_config;
    logic [7:0] low_power_config;
  } psr_cfg_t;

  typedef struct packed {
    logic valid;
    logic [RESULT_W-1:0] raw;
  } psr_sample_t;

  typedef struct packed {
    logic busy;
    logic sunlight;
    logic [13:0] value;
  } psr_autocal_t;
endpackage

/* File: design/psr_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes only when stages two and three agree.
`timescale 1ns/1ps
module psr_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] stable
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1[i] <= RESET_VAL[i];
          s2[i] <= RESET_VAL[i];
          s3[i] <= RESET_VAL[i];
          stable[i] <= RESET_VAL[i];
        end else begin
          s1[i] <= pin[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            stable[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule // psr_sync

/* File: design/psr_persist.sv */
// Threshold window comparison with persistence counting.
// Assumes one result per sample_valid pulse from same-clock logic.
`timescale 1ns/1ps
module psr_persist #(
  parameter int RW = psr_pkg::RESULT_W,
  parameter int TW = psr_pkg::THR_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample_valid,
  input wire logic [RW-1:0] result,
  input wire logic [TW-1:0] low_thr,
  input wire logic [TW-1:0] high_thr,
  input wire logic [1:0] pers_code,
  input wire logic smart_en,
  output logic high_event,
  output logic low_event
);
  logic [2:0] high_cnt;
  logic [2:0] low_cnt;
  logic [2:0] base_req;
  logic [2:0] need;
  logic over;
  logic under;
  logic [2:0] next_high_cnt;
  logic [2:0] next_low_cnt;

  // Codes 0..3 require 1..4 consecutive samples.
  assign base_req = {1'b0, pers_code} + 3'd1;
  // Smart persistence drops one sample from the requirement but never below one.
  assign need = (smart_en && base_req > 3'd1) ? base_req - 3'd1 : base_req;
  assign over = {{(TW-RW){1'b0}}, result} > high_thr;
  assign under = {{(TW-RW){1'b0}}, result} < low_thr;
  assign next_high_cnt = over ? ((high_cnt == 3'd4) ? high_cnt : high_cnt + 3'd1) : 3'd0;
  assign next_low_cnt = under ? ((low_cnt == 3'd4) ? low_cnt : low_cnt + 3'd1) : 3'd0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_cnt <= 3'd0;
      low_cnt <= 3'd0;
      high_event <= 1'b0;
      low_event <= 1'b0;
    end else begin
      high_event <= 1'b0;
      low_event <= 1'b0;
      if (sample_valid) begin
        high_cnt <= next_high_cnt;
        low_cnt <= next_low_cnt;
        // Event fires on the sample that meets the count, and on every later one when the count needed is four.
        high_event <= over && (next_high_cnt == need);
        low_event <= under && (next_low_cnt == need);
      end
    end
  end
endmodule // psr_persist

/* File: dv/psr_port_asserts.sv */
// Concurrent checks on the ports of the proximity sensor register port.
// Assumes binding to psr_port on its single clock with rst_b active low.
`timescale 1ns/1ps
module psr_port_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic int_oe,
  input wire psr_pkg::psr_sample_t sample,
  input wire psr_pkg::psr_cfg_t cfg,
  input wire logic measure_run,
  input wire logic force_trigger
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_reset_vals;
    $rose(rst_b) |-> (cfg == 64'h0100010000000000) && !sda_oe && !int_oe;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad state after reset");

  property p_run_stop;
    measure_run == !cfg.config_two_low[psr_pkg::STOP_BIT];
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("run level wrong");

  property p_ack_low;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("data moved in clock high");

  property p_cfg_write;
    $changed(cfg) |-> !scl_in;
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config changed off a byte end");

  property p_int_cause;
    $rose(int_oe) |-> $past(sample.valid, 2) || $past(sample.valid, 3);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without sample");

  property p_int_off;
    cfg.config_two_low[psr_pkg::MODE_LSB +: 2] == psr_pkg::INT_OFF |-> !int_oe;
  endproperty
  a_int_off: assert property (p_int_off) else $error("interrupt while disabled");

  property p_int_clear;
    $fell(int_oe) |-> !scl_in || $past(sample.valid, 2);
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt dropped oddly");

  property p_force_pulse;
    force_trigger |-> !scl_in ##1 !force_trigger;
  endproperty
  a_force_pulse: assert property (p_force_pulse) else $error("trigger not one pulse");
endmodule // psr_port_asserts

/* File: dv/psr_host_model.sv */
// Behavioural I2C host that issues word transfers to the sensor.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module psr_host_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic bit_io(input logic b, output logic r);
    hw(6);
    sda_drv = b;
    hw(12);
    scl = 1'b1;
    hw(12);
    r = sda_line;
    scl = 1'b0;
  endtask

  task automatic start();
    hw(6);
    sda_drv = 1'b1;
    hw(12);
    scl = 1'b1;
    hw(12);
    sda_drv = 1'b0;
    hw(12);
    scl = 1'b0;
  endtask

  task automatic stop();
    hw(6);
    sda_drv = 1'b0;
    hw(12);
    scl = 1'b1;
    hw(12);
    sda_drv = 1'b1;
    hw(12);
  endtask

  // Sends a byte MSB first, then drives the ninth bit and reports its acknowledge.
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ab, r);
    ack = !r;
  endtask

  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w,
                            output logic ok);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    start();
    xfer({a, 1'b0}, 1'b1, q, k0);
    xfer(c, 1'b1, q, k1);
    xfer(w[7:0], 1'b1, q, k2);
    xfer(w[15:8], 1'b1, q, k3);
    stop();
    ok = k0 & k1 & k2 & k3;
  endtask

  task automatic read_word(input logic [7:0] c, output logic [15:0] w, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    start();
    xfer({psr_pkg::DEV_ADDR, 1'b0}, 1'b1, q, k0);
    xfer(c, 1'b1, q, k1);
    start();
    xfer({psr_pkg::DEV_ADDR, 1'b1}, 1'b1, q, k2);
    xfer(8'hff, 1'b0, w[7:0], k3);
    xfer(8'hff, 1'b1, w[15:8], k3);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule // psr_host_model

/* File: dv/proximity_sensor_register_port_tb.sv */
// Self-checking bench for the proximity sensor register port.
// Assumes psr_pkg is compiled first; the host model drives the I2C pins.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module proximity_sensor_register_port_tb;
  logic clk;
  logic rst_b;
  logic scl;
  logic sda_drv;
  logic sda_oe;
  logic int_oe;
  logic measure_run;
  logic force_trigger;
  logic ok;
  psr_pkg::psr_sample_t sample;
  psr_pkg::psr_autocal_t autocal;
  psr_pkg::psr_cfg_t cfg;
  int err_total;
  int num_checks;
  int trig_cnt = 0;
  wire logic sda_line = sda_drv & ~sda_oe;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts trigger pulses away from the launching edge.
  always @(negedge clk) begin
    if (force_trigger === 1'b1) trig_cnt++;
  end

  psr_port dut (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(),
    .sda_oe(sda_oe), .int_out(), .int_oe(int_oe), .sample(sample), .autocal(autocal),
    .cfg(cfg), .measure_run(measure_run), .force_trigger(force_trigger));

  psr_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] g;
    logic k;
    host.read_word(c, g, k);
    `CHK("ack", 1'b1, k)
    `CHK("read", e, g)
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    logic k;
    host.write_word(psr_pkg::DEV_ADDR, c, v, k);
    `CHK("ack", 1'b1, k)
  endtask

  task automatic smp(input logic [11:0] raw);
    @(posedge clk);
    #1;
    sample = {1'b1, raw};
    @(posedge clk);
    #1;
    sample.valid = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    sample = '0;
    autocal = {1'b1, 1'b1, 14'h1234};
    err_total = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    `CHK("cfg", 64'h0100010000000000, cfg)
    rd(8'h00, 16'h0001);
    rd(8'h03, 16'h0001);
    `CHK("run", 1'b0, measure_run)
    for (int c = 4; c <= 8; c++) rd(8'(c), 16'h0000);
    rd(8'hf8, 16'h0000);
    rd(8'hfa, 16'h00a5);
    rd(8'hfb, 16'hd234);
    host.write_word(7'h61, 8'h05, 16'hffff, ok);
    `CHK("nack", 1'b0, ok)
    rd(8'h05, 16'h0000);
    wr(8'h00, 16'h0003);
    wr(8'h00, 16'h0083);
    rd(8'h00, 16'h0083);
    for (int c = 4; c <= 8; c++) begin
      wr(8'(c), {8'(c) << 4, 8'h40 | 8'(c)});
      rd(8'(c), {8'(c) << 4, 8'h40 | 8'(c)});
    end
    wr(8'hfa, 16'h1234);
    rd(8'hfa, 16'h00a5);
    wr(8'h07, 16'h0010);
    wr(8'h05, 16'h0020);
    wr(8'h06, 16'h0100);
    wr(8'h03, 16'h001c);
    `CHK("run", 1'b1, measure_run)
    smp(12'habc);
    rd(8'hf8, 16'h0aac);
    `CHK("int1", 1'b0, int_oe)
    smp(12'habc);
    `CHK("int2", 1'b1, int_oe)
    rd(8'hf9, 16'h0200);
    `CHK("intclr", 1'b0, int_oe)
    wr(8'h03, 16'h003c);
    repeat (3) smp(12'h005);
    `CHK("int3", 1'b0, int_oe)
    smp(12'h005);
    `CHK("int4", 1'b1, int_oe)
    rd(8'hf9, 16'h0100);
    wr(8'h03, 16'h001e);
    smp(12'habc);
    `CHK("smart", 1'b1, int_oe)
    rd(8'hf9, 16'h0200);
    wr(8'h03, 16'h0010);
    repeat (2) smp(12'h005);
    rd(8'hf9, 16'h0000);
    wr(8'h03, 16'h0008);
    smp(12'h005);
    rd(8'hf9, 16'h0000);
    wr(8'h03, 16'h0004);
    smp(12'habc);
    `CHK("lvl_hi", 1'b1, int_oe)
    rd(8'hf9, 16'h0200);
    `CHK("lvl_hold", 1'b1, int_oe)
    smp(12'h005);
    `CHK("lvl_lo", 1'b0, int_oe)
    rd(8'hf9, 16'h0100);
    wr(8'h04, 16'h0060);
    `CHK("trig", 1, trig_cnt)
    rd(8'h04, 16'h0040);
    wr(8'h03, 16'h0001);
    smp(12'habc);
    rd(8'hf8, 16'h0000);
    print_verdict();
  end
endmodule // proximity_sensor_register_port_tb

bind psr_port psr_port_asserts u_chk (.clk(clk), .rst_b(rst_b), .scl_in(scl_in),
  .sda_oe(sda_oe), .int_oe(int_oe), .sample(sample), .cfg(cfg), .measure_run(measure_run),
  .force_trigger(force_trigger));
